// [kmdc_operator.sv]
/*
  Operator model: turns a requested button set into bouncing,
  active-low pushbutton pins that the model itself drives high when idle.
  Assumes the bench changes the request just after a rising edge.
*/
`timescale 1ns/10ps
module kmdc_operator #(
  parameter int BOUNCE = 6
) (
  input  wire logic       ref_clk,
  input  wire logic [1:0] press,
  output logic            left_button_n,
  output logic            right_button_n
);
  logic [1:0] last_r;
  logic [1:0] chg_r;
  int         bounce_r;

  initial begin
    left_button_n  = 1'b1;
    right_button_n = 1'b1;
    last_r         = 2'b00;
    chg_r          = 2'b00;
    bounce_r       = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Contacts chatter for a few cycles on every change, like real keys
  always @(posedge ref_clk) begin
    last_r <= press;
    if (press != last_r) begin
      bounce_r <= BOUNCE;
      chg_r    <= press ^ last_r;
    end else if (bounce_r > 0) begin
      bounce_r <= bounce_r - 1;
    end
    if (bounce_r > 0) begin
      {right_button_n, left_button_n} <=
        {right_button_n, left_button_n} ^ chg_r;
    end else begin
      {right_button_n, left_button_n} <= ~press;
    end
  end
endmodule : kmdc_operator

// [kmdc_pkg.sv]
/*
  Constants, state codes and segment helpers for the front-panel unit.
  Assumes a 125 MHz system clock; all long intervals use a 1 ms tick.
*/
package kmdc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS       = 1_000_000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // Interval lengths in 1 ms ticks
  localparam logic [4:0]  DEBOUNCE_MS = 5'h14;
  localparam logic [9:0]  HOLD_MS     = 10'h3E8;
  localparam logic [9:0]  PHASE_MS    = 10'h3E8;
  localparam logic [9:0]  BLINK_MS    = 10'h0FA;
  localparam logic [12:0] FLASH_MS    = 13'h1388;
  localparam logic [15:0] IDLE_MS     = 16'hEA60;

  // Top-level menu items
  localparam logic [1:0] ITEM_PARAM = 2'h0;
  localparam logic [1:0] ITEM_NET   = 2'h1;
  localparam logic [1:0] ITEM_FB    = 2'h2;

  // Segment patterns, bit order g f e d c b a, active high
  localparam logic [6:0] SEG_P     = 7'h73;
  localparam logic [6:0] SEG_A     = 7'h77;
  localparam logic [6:0] SEG_I     = 7'h06;
  localparam logic [6:0] SEG_F     = 7'h71;
  localparam logic [6:0] SEG_B     = 7'h7C;
  localparam logic [6:0] SEG_E     = 7'h79;
  localparam logic [6:0] SEG_R     = 7'h50;
  localparam logic [6:0] SEG_SMALLA = 7'h5F;
  localparam logic [6:0] SEG_DASH  = 7'h40;
  localparam logic [6:0] SEG_ALL   = 7'h7F;
  localparam logic [6:0] SEG_BLANK = 7'h00;

  typedef enum logic [6:0] {
    ST_VIEW   = 7'h01,
    ST_TOP    = 7'h02,
    ST_EDIT   = 7'h04,
    ST_FLASH  = 7'h08,
    ST_BUSY   = 7'h10,
    ST_RESULT = 7'h20,
    ST_FAULT  = 7'h40
  } kmdc_state_t;

  function automatic logic [6:0] kmdc_hex7(input logic [3:0] n);
    logic [6:0] lut [16];
    lut = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
            7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    return lut[n];
  endfunction : kmdc_hex7

endpackage : kmdc_pkg

// [kmdc_top.sv]
/*
  Front-panel controller: two seven-segment digits, two pushbuttons,
  menu walk, value entry, flash-to-store and fault presentation.
  Assumes device status and command inputs come from logic on ref_clk;
  button pins are asynchronous and active low.
*/
// Overview of operation
// [RL1] Drive two seven-segment digits and sense two pushbuttons.
// [RL2] After initialisation the default view shows the device state code.
// [RL3] Sixty idle seconds in any menu return to the device state view.
// [RL4] A device fault switches at once to the fault presentation.
// [RL5] Top menu offers parameter, network address and fieldbus entries.
// [RL6] Left action enters menus, then scrolls items without changing settings.
// [RL7] In value entry left changes left digit, right changes right digit.
// [RL8] Right action selects the shown item and descends into it.
// [RL9] Holding right repeats the select each time the readout changes.
// [RL10] Both buttons go up or apply; applied value flashes five seconds, stores.
// [RL11] Any press during the flash cancels the store.
// [RL12] An action runs only after about one second of holding.
// [RL13] Both decimal points flash while a selected function executes.
// [RL14] Unavailable entries show two horizontal lines.
// [RL15] A successful action shows the success indication.
// [RL16] Failures alternate fault and number; device faults add the location.
// [RL17] Values show as two hex digits; parameter menu errors in decimal.
// [RL18] Each fault presentation element stands one second, then repeats.
// [RL19] Buttons are synchronised, debounced; a combo restarts qualification.
// [RL20] All intervals come from a 1 ms prescaler; counters clear on reset.
`timescale 1ns/10ps
module kmdc_top #(
  parameter int unsigned TICK_CYCLES = kmdc_pkg::TICK_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       left_button_n,
  input  wire logic       right_button_n,
  input  wire logic       init_done,
  input  wire logic [7:0] dev_state,
  input  wire logic       dev_fault,
  input  wire logic [7:0] fault_num,
  input  wire logic [7:0] fault_loc,
  input  wire logic       fieldbus_present,
  input  wire logic [7:0] cur_value,
  input  wire logic       func_done,
  input  wire logic       func_err,
  input  wire logic [7:0] func_errnum,
  output logic      [6:0] left_digit,
  output logic      [6:0] right_digit,
  output logic            left_dp,
  output logic            right_dp,
  output logic            cmd_valid,
  output logic      [1:0] cmd_item,
  output logic      [7:0] cmd_value
);

  ////////////////////////////////////////////////////////////////////////////
  kmdc_pkg::kmdc_state_t state_r, state_nxt;
  logic [16:0] pre_r;
  logic [1:0]  raw_s1_r, raw_s2_r, btn_r, combo_r;
  logic [4:0]  deb_r [2];
  logic [9:0]  hold_r, phase_r, blink_cnt_r;
  logic [12:0] flash_r;
  logic [15:0] idle_r;
  logic [1:0]  phase_idx_r, item_r, item_nxt;
  logic [7:0]  value_r, value_nxt;
  logic        blocked_r, blink_r, err_r, err_nxt;
  logic [7:0]  errnum_r;

  wire tick = (pre_r == 17'(TICK_CYCLES - 1)); // RL20
  wire press_edge = |(btn_r & ~combo_r);
  wire act = tick && (btn_r != 2'h0) && (btn_r == combo_r) && !blocked_r
             && (hold_r == kmdc_pkg::HOLD_MS - 10'h001); // RL12
  wire act_left  = act && (btn_r == 2'h1);
  wire act_right = act && (btn_r == 2'h2);
  wire act_both  = act && (btn_r == 2'h3);
  wire idle_hit  = (idle_r == kmdc_pkg::IDLE_MS);
  wire flash_end = tick && (flash_r == kmdc_pkg::FLASH_MS - 13'h0001);
  wire phase_end = tick && (phase_r == kmdc_pkg::PHASE_MS - 10'h001);
  wire avail     = !((item_r == kmdc_pkg::ITEM_FB) && !fieldbus_present);
  wire in_menu   = state_r inside {kmdc_pkg::ST_TOP, kmdc_pkg::ST_EDIT,
                                   kmdc_pkg::ST_RESULT};

  function automatic logic [7:0] to_dec(input logic [7:0] n);
    logic [7:0] t;
    t = n / 8'h0A;
    return {t[3:0], 4'(n - t * 8'h0A)};
  endfunction : to_dec

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler, synchroniser and debounce
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pre_r <= '0;
    end else begin
      pre_r <= tick ? 17'h0_0000 : pre_r + 17'h0_0001; // RL20
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      raw_s1_r <= '0;
      raw_s2_r <= '0;
    end else begin
      raw_s1_r <= {~right_button_n, ~left_button_n}; // RL19
      raw_s2_r <= raw_s1_r;
    end
  end

  // Needs DEBOUNCE_MS of stable level; bounce shorter than that is ignored
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      btn_r <= '0;
      deb_r <= '{5'h00, 5'h00};
    end else if (tick) begin
      for (int i = 0; i < 2; i++) begin
        if (raw_s2_r[i] == btn_r[i]) begin
          deb_r[i] <= 5'h00;
        end else if (deb_r[i] == kmdc_pkg::DEBOUNCE_MS) begin
          btn_r[i] <= raw_s2_r[i]; // RL19
          deb_r[i] <= 5'h00;
        end else begin
          deb_r[i] <= deb_r[i] + 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Press qualification; a changed combination restarts the hold
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      combo_r   <= '0;
      hold_r    <= '0;
      blocked_r <= 1'b0;
    end else begin
      combo_r <= btn_r;
      if (btn_r != combo_r || btn_r == 2'h0) begin
        hold_r <= 10'h000; // RL19
      end else if (tick) begin
        hold_r <= act ? 10'h000 : hold_r + 10'h001; // RL9
      end
      // Both-button actions and aborts must not repeat while held
      if (btn_r == 2'h0) begin
        blocked_r <= 1'b0;
      end else if (act_both || (state_r == kmdc_pkg::ST_FLASH && press_edge))
      begin
        blocked_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      idle_r <= '0;
    end else if (btn_r != 2'h0 || !in_menu) begin
      idle_r <= 16'h0000;
    end else if (tick && !idle_hit) begin
      idle_r <= idle_r + 16'h0001; // RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval counters
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flash_r     <= '0;
      phase_r     <= '0;
      phase_idx_r <= '0;
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
    end else begin
      if (state_r != kmdc_pkg::ST_FLASH) begin
        flash_r <= 13'h0000;
      end else if (tick) begin
        flash_r <= flash_r + 13'h0001; // RL10
      end
      if (state_r != state_nxt) begin
        phase_r     <= 10'h000;
        phase_idx_r <= 2'h0;
      end else if (phase_end) begin
        phase_r     <= 10'h000;
        phase_idx_r <= (phase_idx_r == 2'h2 ||
                        (state_r != kmdc_pkg::ST_FAULT && phase_idx_r == 2'h1))
                       ? 2'h0 : phase_idx_r + 2'h1; // RL18
      end else if (tick) begin
        phase_r <= phase_r + 10'h001;
      end
      if (tick) begin
        if (blink_cnt_r == kmdc_pkg::BLINK_MS - 10'h001) begin
          blink_cnt_r <= 10'h000;
          blink_r     <= ~blink_r;
        end else begin
          blink_cnt_r <= blink_cnt_r + 10'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Menu state machine
  always_comb begin
    state_nxt = state_r;
    item_nxt  = item_r;
    value_nxt = value_r;
    err_nxt   = err_r;
    unique case (state_r)
      kmdc_pkg::ST_VIEW: begin
        if (act_left) begin
          state_nxt = kmdc_pkg::ST_TOP; // RL6
          item_nxt  = kmdc_pkg::ITEM_PARAM;
        end
      end
      kmdc_pkg::ST_TOP: begin
        if (act_left) begin
          item_nxt = (item_r == kmdc_pkg::ITEM_FB) ? kmdc_pkg::ITEM_PARAM
                                                   : item_r + 2'h1; // RL6
        end else if (act_right) begin
          state_nxt = kmdc_pkg::ST_EDIT; // RL8
          value_nxt = cur_value;
        end else if (act_both) begin
          state_nxt = kmdc_pkg::ST_VIEW; // RL10
        end
      end
      kmdc_pkg::ST_EDIT: begin
        if (act_both) begin
          state_nxt = avail ? kmdc_pkg::ST_FLASH : kmdc_pkg::ST_TOP; // RL10
        end else if (avail && item_r != kmdc_pkg::ITEM_PARAM) begin
          if (act_left) begin
            value_nxt = {value_r[7:4] + 4'h1, value_r[3:0]}; // RL7
          end else if (act_right) begin
            value_nxt = {value_r[7:4], value_r[3:0] + 4'h1}; // RL7
          end
        end
      end
      kmdc_pkg::ST_FLASH: begin
        if (press_edge) begin
          state_nxt = kmdc_pkg::ST_EDIT; // RL11
        end else if (flash_end) begin
          state_nxt = kmdc_pkg::ST_BUSY; // RL10
        end
      end
      kmdc_pkg::ST_BUSY: begin
        if (func_done) begin
          state_nxt = kmdc_pkg::ST_RESULT;
          err_nxt   = func_err;
        end
      end
      kmdc_pkg::ST_RESULT: begin
        if (act) begin
          state_nxt = kmdc_pkg::ST_TOP;
        end
      end
      kmdc_pkg::ST_FAULT: begin
        if (!dev_fault) begin
          state_nxt = kmdc_pkg::ST_VIEW;
        end
      end
    endcase
    if (in_menu && idle_hit) begin
      state_nxt = kmdc_pkg::ST_VIEW; // RL3
    end
    if (dev_fault) begin
      state_nxt = kmdc_pkg::ST_FAULT; // RL4
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_r  <= kmdc_pkg::ST_VIEW;
      item_r   <= '0;
      value_r  <= '0;
      err_r    <= 1'b0;
      errnum_r <= '0;
    end else begin
      state_r <= state_nxt;
      item_r  <= item_nxt;
      value_r <= value_nxt;
      err_r   <= err_nxt;
      if (state_r == kmdc_pkg::ST_BUSY && func_done) begin
        errnum_r <= (item_r == kmdc_pkg::ITEM_PARAM) ? to_dec(func_errnum)
                                                     : func_errnum; // RL17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readout selection
  logic [6:0] lbl_l, lbl_r, edit_l, edit_r, seg_l_nxt, seg_r_nxt;
  assign lbl_l = (item_r == kmdc_pkg::ITEM_PARAM) ? kmdc_pkg::SEG_P :
                 (item_r == kmdc_pkg::ITEM_NET) ? kmdc_pkg::SEG_I
                                                : kmdc_pkg::SEG_F; // RL5
  assign lbl_r = (item_r == kmdc_pkg::ITEM_PARAM) ? kmdc_pkg::SEG_A :
                 (item_r == kmdc_pkg::ITEM_NET) ? kmdc_pkg::SEG_P
                                                : kmdc_pkg::SEG_B; // RL5
  assign edit_l = !avail ? kmdc_pkg::SEG_DASH :                   // RL14
                  (item_r == kmdc_pkg::ITEM_PARAM) ? lbl_l :
                  kmdc_pkg::kmdc_hex7(value_r[7:4]);              // RL17
  assign edit_r = !avail ? kmdc_pkg::SEG_DASH :                   // RL14
                  (item_r == kmdc_pkg::ITEM_PARAM) ? lbl_r :
                  kmdc_pkg::kmdc_hex7(value_r[3:0]);
  wire [7:0] shown = (state_r == kmdc_pkg::ST_FAULT) ?
                     ((phase_idx_r == 2'h1) ? fault_num : fault_loc) :
                     errnum_r;
  wire show_er = (phase_idx_r == 2'h0);

  always_comb begin
    seg_l_nxt = kmdc_pkg::SEG_BLANK;
    seg_r_nxt = kmdc_pkg::SEG_BLANK;
    unique case (state_r)
      kmdc_pkg::ST_VIEW: begin
        seg_l_nxt = init_done ? kmdc_pkg::kmdc_hex7(dev_state[7:4])
                              : kmdc_pkg::SEG_ALL; // RL2
        seg_r_nxt = init_done ? kmdc_pkg::kmdc_hex7(dev_state[3:0])
                              : kmdc_pkg::SEG_ALL;
      end
      kmdc_pkg::ST_TOP: begin
        seg_l_nxt = lbl_l;
        seg_r_nxt = lbl_r;
      end
      kmdc_pkg::ST_EDIT, kmdc_pkg::ST_BUSY: begin
        seg_l_nxt = edit_l;
        seg_r_nxt = edit_r;
      end
      kmdc_pkg::ST_FLASH: begin
        seg_l_nxt = blink_r ? edit_l : kmdc_pkg::SEG_BLANK; // RL10
        seg_r_nxt = blink_r ? edit_r : kmdc_pkg::SEG_BLANK;
      end
      kmdc_pkg::ST_RESULT, kmdc_pkg::ST_FAULT: begin
        if (state_r == kmdc_pkg::ST_RESULT && !err_r) begin
          seg_l_nxt = kmdc_pkg::SEG_SMALLA; // RL15
          seg_r_nxt = kmdc_pkg::SEG_F;
        end else if (show_er) begin
          seg_l_nxt = kmdc_pkg::SEG_E; // RL16
          seg_r_nxt = kmdc_pkg::SEG_R;
        end else begin
          seg_l_nxt = kmdc_pkg::kmdc_hex7(shown[7:4]); // RL16
          seg_r_nxt = kmdc_pkg::kmdc_hex7(shown[3:0]);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      left_digit  <= '0;
      right_digit <= '0;
      left_dp     <= 1'b0;
      right_dp    <= 1'b0;
      cmd_valid   <= 1'b0;
      cmd_item    <= '0;
      cmd_value   <= '0;
    end else begin
      left_digit  <= seg_l_nxt; // RL1
      right_digit <= seg_r_nxt;
      left_dp     <= (state_r == kmdc_pkg::ST_BUSY) && blink_r; // RL13
      right_dp    <= (state_r == kmdc_pkg::ST_BUSY) && blink_r;
      cmd_valid   <= (state_r == kmdc_pkg::ST_FLASH) && flash_end
                     && !press_edge && !dev_fault; // RL10
      if (state_r == kmdc_pkg::ST_FLASH) begin
        cmd_item  <= item_r;
        cmd_value <= value_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the pressed set last changed or last fired
  logic [31:0] ast_run_r;
  always_ff @(posedge ref_clk) begin
    if (!resetn || btn_r != combo_r || btn_r == 2'h0 || act) begin
      ast_run_r <= '0;
    end else begin
      ast_run_r <= ast_run_r + 32'h0000_0001;
    end
  end

  AST_FAULT_OVERRIDE: assert property ( // RL4
    @(posedge ref_clk) disable iff (!resetn)
    dev_fault |=> state_r == kmdc_pkg::ST_FAULT)
    else $error("fault did not take over the readout");

  AST_IDLE_RETURN: assert property ( // RL3
    @(posedge ref_clk) disable iff (!resetn)
    (in_menu && idle_hit && !dev_fault) |=> state_r == kmdc_pkg::ST_VIEW)
    else $error("idle timeout did not return to state view");

  AST_FLASH_ABORT: assert property ( // RL11
    @(posedge ref_clk) disable iff (!resetn)
    (state_r == kmdc_pkg::ST_FLASH && press_edge && !dev_fault)
    |=> state_r == kmdc_pkg::ST_EDIT ##1 !cmd_valid)
    else $error("press during flash did not cancel store");

  AST_STORE_TIMING: assert property ( // RL10
    @(posedge ref_clk) disable iff (!resetn)
    $rose(cmd_valid) |-> $past(state_r) == kmdc_pkg::ST_FLASH
      && $past(flash_r) == kmdc_pkg::FLASH_MS - 13'h0001)
    else $error("store issued outside the end of the flash");

  // Counted in plain cycles, apart from the tick-based hold counter
  AST_HOLD_QUAL: assert property ( // RL12
    @(posedge ref_clk) disable iff (!resetn)
    act |-> btn_r == $past(btn_r) && ast_run_r >=
      (32'(kmdc_pkg::HOLD_MS) - 32'h0000_0001) * 32'(TICK_CYCLES))
    else $error("action without full hold time");

  AST_BUSY_DP: assert property ( // RL13
    @(posedge ref_clk) disable iff (!resetn)
    state_r == kmdc_pkg::ST_BUSY |=> left_dp == $past(blink_r)
      && right_dp == left_dp)
    else $error("decimal points not flashing while busy");

  AST_LEFT_SCROLL: assert property ( // RL6
    @(posedge ref_clk) disable iff (!resetn)
    (state_r == kmdc_pkg::ST_TOP && act_left && !dev_fault && !idle_hit)
    |=> state_r == kmdc_pkg::ST_TOP && item_r != $past(item_r)
      && value_r == $past(value_r))
    else $error("left action did not scroll cleanly");

  AST_VIEW_DEFAULT: assert property ( // RL2
    @(posedge ref_clk) disable iff (!resetn)
    (state_r == kmdc_pkg::ST_VIEW && init_done)
    |=> left_digit == kmdc_pkg::kmdc_hex7($past(dev_state[7:4])))
    else $error("state view does not show the device state");

endmodule : kmdc_top

// [tb_kmdc_top.sv]
/*
  Self-checking bench for the front-panel controller: menu walk, value
  entry, flash abort and store, result, fault presentation.
  Assumes a shortened tick so one second is a few thousand cycles.
*/
`timescale 1ns/10ps
module tb_kmdc_top;
  localparam int T    = 4;
  localparam int HOLD = T * int'(kmdc_pkg::HOLD_MS);
  localparam int PH   = T * int'(kmdc_pkg::PHASE_MS);
  localparam int FL   = T * int'(kmdc_pkg::FLASH_MS);
  localparam int BLK  = T * int'(kmdc_pkg::BLINK_MS);
  localparam int LIM  = HOLD + T * int'(kmdc_pkg::DEBOUNCE_MS) + 4 * T + 16;
  localparam int REL  = T * int'(kmdc_pkg::DEBOUNCE_MS) + 40;

  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       left_button_n;
  logic       right_button_n;
  logic       init_done = 1'b0;
  logic [7:0] dev_state = 8'h00;
  logic       dev_fault = 1'b0;
  logic [7:0] fault_num = 8'h00;
  logic [7:0] fault_loc = 8'h00;
  logic       fieldbus_present = 1'b1;
  logic [7:0] cur_value = 8'h00;
  logic       func_done = 1'b0;
  logic       func_err = 1'b0;
  logic [7:0] func_errnum = 8'h00;
  logic [6:0] left_digit;
  logic [6:0] right_digit;
  logic       left_dp;
  logic       right_dp;
  logic       cmd_valid;
  logic [1:0] cmd_item;
  logic [7:0] cmd_value;
  logic [1:0] req = 2'b00;
  logic [6:0] hex_seg [16];
  logic [7:0] ev;
  logic [13:0] q [$];
  int         errors = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         pulses = 0;
  int         t0;
  int         n;
  logic [1:0] seen;

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  always @(posedge ref_clk) if (cmd_valid === 1'b1) pulses <= pulses + 1;

  kmdc_top #(.TICK_CYCLES(T)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn),
    .left_button_n(left_button_n), .right_button_n(right_button_n),
    .init_done(init_done), .dev_state(dev_state), .dev_fault(dev_fault),
    .fault_num(fault_num), .fault_loc(fault_loc),
    .fieldbus_present(fieldbus_present), .cur_value(cur_value),
    .func_done(func_done), .func_err(func_err),
    .func_errnum(func_errnum), .left_digit(left_digit),
    .right_digit(right_digit), .left_dp(left_dp), .right_dp(right_dp),
    .cmd_valid(cmd_valid), .cmd_item(cmd_item), .cmd_value(cmd_value)
  );

  kmdc_operator u_op (
    .ref_clk(ref_clk), .press(req),
    .left_button_n(left_button_n), .right_button_n(right_button_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // Reference model helpers, own segment table kept apart from design
  function automatic logic [13:0] h2(input logic [7:0] v);
    return {hex_seg[v[7:4]], hex_seg[v[3:0]]};
  endfunction : h2

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk

  task automatic disp(input logic [13:0] e, input string m);
    @(negedge ref_clk);
    chk({left_digit, right_digit} === e, m);
  endtask : disp

  // Hold zero waits for the readout to move, then lets go at once
  task automatic press(input logic [1:0] b, input int hold);
    logic [13:0] s;
    int k;
    s = {left_digit, right_digit};
    k = 0;
    @(posedge ref_clk) req <= b;
    if (hold > 0) begin
      repeat (hold) @(posedge ref_clk);
    end else begin
      while ({left_digit, right_digit} === s && k < LIM) begin
        @(negedge ref_clk);
        k++;
      end
      chk(k >= HOLD && k < LIM, "action qualification time");
    end
    @(posedge ref_clk) req <= 2'b00;
    repeat (REL) @(posedge ref_clk);
  endtask : press

  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////
  // Watchdog sized from the planned walk plus margin
  initial begin
    repeat (110000) @(posedge ref_clk);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    hex_seg = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
                7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    void'($urandom(64688));
    dev_state = 8'($urandom);
    cur_value = 8'($urandom);
    fault_num = 8'($urandom);
    fault_loc = 8'($urandom);
    func_errnum = 8'($urandom);
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(left_digit === 7'h00 && cmd_valid === 1'b0, "reset outputs");
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    disp({kmdc_pkg::SEG_ALL, kmdc_pkg::SEG_ALL}, "init view");
    @(posedge ref_clk) init_done <= 1'b1;
    repeat (3) @(posedge ref_clk);
    disp(h2(dev_state), "state view");
    // Menu walk and an unavailable fieldbus entry
    press(2'b01, 0);
    disp({kmdc_pkg::SEG_P, kmdc_pkg::SEG_A}, "param label");
    press(2'b01, 0);
    disp({kmdc_pkg::SEG_I, kmdc_pkg::SEG_P}, "net label");
    press(2'b01, 0);
    disp({kmdc_pkg::SEG_F, kmdc_pkg::SEG_B}, "fieldbus label");
    @(posedge ref_clk) fieldbus_present <= 1'b0;
    press(2'b10, 0);
    disp({kmdc_pkg::SEG_DASH, kmdc_pkg::SEG_DASH}, "unavailable");
    // Fault overrides the menu and cycles its three elements
    @(posedge ref_clk) dev_fault <= 1'b1;
    t0 = cyc;
    repeat (3) @(posedge ref_clk);
    disp({kmdc_pkg::SEG_E, kmdc_pkg::SEG_R}, "fault at once");
    q = '{{kmdc_pkg::SEG_E, kmdc_pkg::SEG_R}, h2(fault_num), h2(fault_loc),
          {kmdc_pkg::SEG_E, kmdc_pkg::SEG_R}};
    for (int i = 1; i < 4; i++) begin
      while (cyc < t0 + i * PH - 12) @(posedge ref_clk);
      disp(q[i-1], "fault element held");
      while (cyc < t0 + i * PH + 12) @(posedge ref_clk);
      disp(q[i], "fault element next");
    end
    @(posedge ref_clk) dev_fault <= 1'b0;
    fieldbus_present <= 1'b1;
    repeat (3) @(posedge ref_clk);
    disp(h2(dev_state), "back to state view");
    // Edit the network item, abort one store, then store
    press(2'b01, 0);
    press(2'b01, 0);
    press(2'b10, 0);
    ev = cur_value;
    disp(h2(ev), "edit start");
    press(2'b01, 0);
    ev[7:4] = ev[7:4] + 4'h1;
    disp(h2(ev), "left digit step");
    press(2'b10, 0);
    ev[3:0] = ev[3:0] + 4'h1;
    disp(h2(ev), "right digit step");
    n = pulses;
    press(2'b11, LIM);
    press(2'b01, 200);
    repeat (FL) @(posedge ref_clk);
    chk(pulses == n, "aborted store");
    disp(h2(ev), "value kept after abort");
    press(2'b11, LIM);
    t0 = 0;
    while (pulses == n && t0 < FL + 400) begin
      @(posedge ref_clk);
      t0++;
    end
    chk(t0 >= FL - 200 && t0 <= FL + 20, "flash length");
    @(negedge ref_clk);
    chk(cmd_item === kmdc_pkg::ITEM_NET, "store item");
    chk(cmd_value === ev, "store value");
    seen = 2'b00;
    repeat (2 * BLK) begin
      @(negedge ref_clk);
      if (left_dp === 1'b1 && right_dp === 1'b1) seen[1] = 1'b1;
      if (left_dp === 1'b0 && right_dp === 1'b0) seen[0] = 1'b1;
    end
    chk(seen == 2'b11, "busy points blink");
    @(posedge ref_clk) func_done <= 1'b1;
    @(posedge ref_clk) func_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    disp({kmdc_pkg::SEG_SMALLA, kmdc_pkg::SEG_F}, "success");
    chk(left_dp === 1'b0 && right_dp === 1'b0, "points off");
    conclude();
  end
endmodule : tb_kmdc_top
